// >>> inc/nvc_pkg.sv
// Package: register map, field positions and timing of the NVM control block
package nvc_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] NVC_OFS_DEV_CTRL = 8'h01;
	localparam logic [7:0] NVC_OFS_TEMP_HI = 8'h05;
	localparam logic [7:0] NVC_OFS_TEMP_LO = 8'h06;
	localparam logic [7:0] NVC_OFS_XFER_CTRL = 8'h72;
	localparam logic [7:0] NVC_OFS_CFG_FIRST = 8'hA0;
	localparam logic [7:0] NVC_OFS_CFG_LAST = 8'hA7;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int NVC_IDLE_FLAG_POS = 7;
	localparam int NVC_ARM_POS = 2;
	localparam int NVC_STORE_POS = 1;
	localparam int NVC_RELOAD_POS = 0;
	localparam int NVC_TEMP_LO_POS = 5;
	localparam int NVC_CFG_COUNT = 8;
	localparam int NVC_CFG_IDX_W = 3;
	localparam logic [7:0] NVC_XFER_RST = 8'h00;
	localparam logic [7:0] NVC_DEV_CTRL_RST = 8'h00;
	localparam logic [7:0] NVC_TEMP_RST = 8'h00;

	// ************************************************************
	// Timing: one cell write/read of the non-volatile array
	// ************************************************************
	localparam int NVC_CLK_HZ = 25_000_000;
	localparam int NVC_CELL_TIME_US = 20;
	localparam int NVC_CELL_CYCLES = (NVC_CELL_TIME_US * (NVC_CLK_HZ / 1000))
		/ 1000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} nvc_req_type;

	typedef struct packed {
		logic en;
		logic wr;
		logic [NVC_CFG_IDX_W-1:0] idx;
		logic [7:0] wdata;
	} nvc_cell_type;

	typedef enum logic [1:0] {
		NVC_IDLE,
		NVC_STORE,
		NVC_RELOAD
	} nvc_state_type;

endpackage : nvc_pkg

// >>> rtl/nvc_cell_array.sv
// Non-volatile cell array model: eight bytes with a timed access per cell
`timescale 1ns/1ps
module nvc_cell_array
	import nvc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire nvc_cell_type cmd_i,
	output logic done_o,
	output logic [7:0] rdata_o
);
	logic [7:0] cell_r [NVC_CFG_COUNT];
	logic [15:0] cnt_r;
	logic busy_r;
	nvc_cell_type hold_r;

	// ************************************************************
	// Access timer; cells persist across rst_i like real storage
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			cnt_r <= 16'h0000;
			hold_r <= '0;
		end else if (!busy_r && cmd_i.en) begin
			busy_r <= 1'b1;
			cnt_r <= 16'(NVC_CELL_CYCLES - 1);
			hold_r <= cmd_i;
		end else if (busy_r && cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else begin
			busy_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (busy_r && cnt_r == 16'h0000 && hold_r.wr) begin
			cell_r[hold_r.idx] <= hold_r.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (!busy_r && cmd_i.en) begin
			// Taken at the start so it already stands when done rises
			rdata_o <= cell_r[cmd_i.idx];
		end
	end

	assign done_o = busy_r && cnt_r == 16'h0000;

endmodule : nvc_cell_array

// >>> rtl/nvc_ctrl.sv
// NVM transfer control, configuration registers and temperature readout
`timescale 1ns/1ps
module nvc_ctrl
	import nvc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire nvc_req_type req_i,
	input wire logic [10:0] temp_i,
	output logic [7:0] rdata_o,
	output logic [63:0] cfg_o,
	output logic [7:0] dev_ctrl_o,
	output logic nvm_idle_flag_o
);
	logic [7:0] cfg_r [NVC_CFG_COUNT];
	logic [7:0] xfer_r;
	logic [7:0] dev_ctrl_r;
	logic [10:0] temp_s1_r;
	logic [10:0] temp_s2_r;
	logic [10:0] temp_s3_r;
	logic [10:0] temp_val_r;
	logic [10:0] temp_lat_r;
	logic armed_r;
	logic boot_r;
	logic issued_r;
	logic [NVC_CFG_IDX_W-1:0] idx_r;
	nvc_state_type state_r;
	nvc_cell_type cell_cmd;
	logic cell_done;
	logic [7:0] cell_rdata;
	logic cfg_hit;
	logic last_cell;

	function automatic logic in_cfg(input logic [7:0] a);
		in_cfg = a >= NVC_OFS_CFG_FIRST && a <= NVC_OFS_CFG_LAST;
	endfunction : in_cfg

	assign cfg_hit = in_cfg(req_i.addr);
	assign last_cell = idx_r == NVC_CFG_IDX_W'(NVC_CFG_COUNT - 1);

	// ************************************************************
	// Temperature input synchroniser and read latch
	// ************************************************************
	always_ff @(posedge clk_i) begin
		temp_s1_r <= temp_i;
		temp_s2_r <= temp_s1_r;
		temp_s3_r <= temp_s2_r;
	end

	// Bits cross one by one; take a word only once two samples agree
	always_ff @(posedge clk_i) begin
		if (temp_s2_r == temp_s3_r) begin
			temp_val_r <= temp_s2_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			temp_lat_r <= 11'h000;
		end else if (req_i.rd && req_i.addr == NVC_OFS_TEMP_HI) begin
			temp_lat_r <= temp_val_r;
		end
	end

	// ************************************************************
	// Device control register
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dev_ctrl_r <= NVC_DEV_CTRL_RST;
		end else if (req_i.wr && req_i.addr == NVC_OFS_DEV_CTRL) begin
			dev_ctrl_r <= {5'h00, req_i.wdata[2:0]};
		end
	end

	// ************************************************************
	// Transfer control register and arming
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xfer_r <= NVC_XFER_RST;
		end else if (req_i.wr && req_i.addr == NVC_OFS_XFER_CTRL) begin
			xfer_r <= {5'h00, req_i.wdata[2:0]};
		end
	end

	// Arm survives the 04h->02h write, cleared once a transfer starts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_r <= 1'b0;
		end else if (req_i.wr && req_i.addr == NVC_OFS_XFER_CTRL
			&& req_i.wdata[NVC_ARM_POS]) begin
			armed_r <= 1'b1;
		end else if (state_r != NVC_IDLE) begin
			armed_r <= 1'b0;
		end
	end

	// ************************************************************
	// Transfer sequencer
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= NVC_RELOAD;
			boot_r <= 1'b1;
		end else begin
			case (state_r)
				NVC_IDLE: begin
					if (armed_r && xfer_r[NVC_STORE_POS]) begin
						state_r <= NVC_STORE;
					end else if (armed_r && xfer_r[NVC_RELOAD_POS]) begin
						state_r <= NVC_RELOAD;
					end
				end
				NVC_STORE, NVC_RELOAD: begin
					if (cell_done && last_cell) begin
						state_r <= NVC_IDLE;
						boot_r <= 1'b0;
					end
				end
				default: begin
					state_r <= NVC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_r == NVC_IDLE) begin
			idx_r <= '0;
			issued_r <= 1'b0;
		end else if (cell_done) begin
			idx_r <= idx_r + 1'b1;
			issued_r <= 1'b0;
		end else begin
			issued_r <= 1'b1;
		end
	end

	always_comb begin
		cell_cmd.en = state_r != NVC_IDLE && !issued_r && !cell_done;
		cell_cmd.wr = state_r == NVC_STORE;
		cell_cmd.idx = idx_r;
		cell_cmd.wdata = cfg_r[idx_r];
	end

	nvc_cell_array u_cells (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cmd_i(cell_cmd),
		.done_o(cell_done),
		.rdata_o(cell_rdata)
	);

	// ************************************************************
	// Configuration registers: volatile, written by host or reload
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NVC_CFG_COUNT; i++) begin
				cfg_r[i] <= 8'h00;
			end
		end else if (state_r == NVC_RELOAD && cell_done) begin
			cfg_r[idx_r] <= cell_rdata;
		end else if (req_i.wr && cfg_hit) begin
			cfg_r[req_i.addr[2:0]] <= req_i.wdata;
		end
	end

	always_comb begin
		for (int i = 0; i < NVC_CFG_COUNT; i++) begin
			cfg_o[i*8 +: 8] = cfg_r[i];
		end
	end

	assign dev_ctrl_o = dev_ctrl_r;
	assign nvm_idle_flag_o = state_r == NVC_IDLE;

	// ************************************************************
	// Read data
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (req_i.rd) begin
			if (req_i.addr == NVC_OFS_TEMP_HI) begin
				rdata_o <= temp_val_r[10:3];
			end else if (req_i.addr == NVC_OFS_TEMP_LO) begin
				rdata_o <= {temp_lat_r[2:0], 5'h00};
			end else if (req_i.addr == NVC_OFS_XFER_CTRL) begin
				rdata_o <= {state_r == NVC_IDLE, 4'h0, xfer_r[2:0]};
			end else if (req_i.addr == NVC_OFS_DEV_CTRL) begin
				rdata_o <= dev_ctrl_r;
			end else if (cfg_hit) begin
				rdata_o <= cfg_r[req_i.addr[2:0]];
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	sequence store_go_s;
		state_r == NVC_IDLE && armed_r && xfer_r[NVC_STORE_POS];
	endsequence

	idle_flag_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		store_go_s |=> !nvm_idle_flag_o)
		else $error("idle flag not low after store start");
	store_no_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_r == NVC_STORE) |-> $past(armed_r))
		else $error("store began without arming");
	temp_lo_fmt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req_i.rd && req_i.addr == NVC_OFS_TEMP_LO
		|=> rdata_o[4:0] == 5'h00 && rdata_o[7:5] == $past(temp_lat_r[2:0]))
		else $error("temperature low byte wrong");
	temp_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req_i.rd && req_i.addr == NVC_OFS_TEMP_HI
		|=> temp_lat_r[10:3] == rdata_o)
		else $error("temperature latch mismatch");
	ready_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req_i.rd && req_i.addr == NVC_OFS_XFER_CTRL
		|=> rdata_o[7] == $past(nvm_idle_flag_o))
		else $error("ready bit differs from state");
	cfg_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req_i.wr && cfg_hit && state_r != NVC_RELOAD
		|=> cfg_o[$past(req_i.addr[2:0])*8 +: 8] == $past(req_i.wdata))
		else $error("configuration write not immediate");
	// Boot copies are left out; the bench judges the one after the store and the one at the second boot
	reload_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == NVC_RELOAD && cell_done && !boot_r
		|=> cfg_r[$past(idx_r)] == $past(cell_rdata))
		else $error("reload did not copy cell");
	store_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == NVC_STORE && cell_done && last_cell
		|=> nvm_idle_flag_o)
		else $error("store did not finish");

endmodule : nvc_ctrl

// >>> tb/nvc_host.sv
// Host controller model issuing register requests to the NVM block
`timescale 1ns/1ps
module nvc_host
	import nvc_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	input wire logic idle_i,
	output nvc_req_type req_o
);
	// ************************************************************
	// Register access
	// ************************************************************
	initial req_o = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		#1 req_o.wr = 1'b0;
	endtask : wr

	// Data sampled after the taking edge, where it is settled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		#1 req_o.rd = 1'b0;
		d = rdata_i;
	endtask : rd

	task automatic wait_idle(output bit ok);
		ok = 1'b0;
		for (int n = 0; n < 5000 && !ok; n++) begin
			@(posedge clk_i);
			#1 ok = (idle_i === 1'b1);
		end
	endtask : wait_idle

	// ************************************************************
	// Transfer sequence, used on validation runs only
	// ************************************************************
	task automatic xfer(input logic [7:0] cmd, output logic busy,
		output bit ok);
		wr(NVC_OFS_DEV_CTRL, 8'h05);
		wr(NVC_OFS_XFER_CTRL, 8'h04);
		wr(NVC_OFS_XFER_CTRL, cmd);
		@(posedge clk_i);
		#1 busy = idle_i;
		// Polling the flag instead of a fixed wait keeps runs short
		wait_idle(ok);
		wr(NVC_OFS_XFER_CTRL, 8'h00);
	endtask : xfer
endmodule : nvc_host

// >>> tb/testbench.sv
// Self-checking testbench of the NVM transfer control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench
	import nvc_pkg::*;
;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic clk_i = 1'b0;
	logic rst_i;
	nvc_req_type req;
	logic [10:0] temp_i;
	logic [7:0] rdata;
	logic [63:0] cfg_o;
	logic [7:0] dev_ctrl;
	logic idle;
	logic [7:0] d;
	logic busy;
	bit ok;
	logic [63:0] img;
	logic [63:0] saved;
	int error_cnt = 0;
	int checks = 0;

	always #20 clk_i = ~clk_i;

	nvc_ctrl nvc_ctrl_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(req),
		.temp_i(temp_i),
		.rdata_o(rdata),
		.cfg_o(cfg_o),
		.dev_ctrl_o(dev_ctrl),
		.nvm_idle_flag_o(idle)
	);

	nvc_host nvc_host_inst (
		.clk_i(clk_i),
		.rdata_i(rdata),
		.idle_i(idle),
		.req_o(req)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic stop_test;
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic wcfg(input logic [7:0] k);
		for (int i = 0; i < NVC_CFG_COUNT; i++) begin
			img[8*i +: 8] = k + 8'(i);
			nvc_host_inst.wr(NVC_OFS_CFG_FIRST + 8'(i), img[8*i +: 8]);
			`CHK(cfg_o[8*i +: 8], img[8*i +: 8])
		end
	endtask : wcfg

	task automatic boot;
		repeat (2) @(posedge clk_i);
		#1 rst_i = 1'b0;
		@(posedge clk_i);
		#1 `CHK(idle, 1'b0)
		nvc_host_inst.wait_idle(ok);
		`CHK(ok, 1'b1)
	endtask : boot

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst_i = 1'b1;
		temp_i = 11'h5A5;
		boot();
		nvc_host_inst.rd(NVC_OFS_XFER_CTRL, d);
		`CHK(d, 8'h80)
		// High byte first; sample changes before the low byte read
		nvc_host_inst.rd(NVC_OFS_TEMP_HI, d);
		`CHK(d, 8'hB4)
		temp_i = 11'h000;
		repeat (3) @(posedge clk_i);
		nvc_host_inst.rd(NVC_OFS_TEMP_LO, d);
		`CHK(d, 8'hA0)
		nvc_host_inst.rd(8'h10, d);
		`CHK(d, 8'h00)
		wcfg(8'h31);
		saved = img;
		nvc_host_inst.xfer(8'h02, busy, ok);
		`CHK(dev_ctrl, 8'h05)
		`CHK(busy, 1'b0)
		`CHK(ok, 1'b1)
		wcfg(8'hC0);
		nvc_host_inst.xfer(8'h01, busy, ok);
		`CHK(busy, 1'b0)
		`CHK(ok, 1'b1)
		`CHK(cfg_o, saved)
		nvc_host_inst.rd(NVC_OFS_CFG_LAST, d);
		`CHK(d, saved[63:56])
		// Store request without arming must not start
		nvc_host_inst.wr(NVC_OFS_XFER_CTRL, 8'h02);
		@(posedge clk_i);
		#1 `CHK(idle, 1'b1)
		nvc_host_inst.rd(NVC_OFS_XFER_CTRL, d);
		`CHK(d, 8'h82)
		nvc_host_inst.wr(NVC_OFS_XFER_CTRL, 8'h00);
		wcfg(8'h70);
		@(posedge clk_i);
		#1 rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 `CHK(cfg_o, 64'h0)
		boot();
		`CHK(cfg_o, saved)
		stop_test();
	end

	initial begin
		#2_000_000;
		error_cnt++;
		stop_test();
	end
endmodule : testbench
